// [include/fm_consts.svh]
// Constants for the fan monitor start-up and configuration block
`ifndef FM_CONSTS_SVH
`define FM_CONSTS_SVH

// Register offsets
`define FM_REG_EXTCFG   8'h7c
`define FM_REG_CFG4     8'h7d
`define FM_REG_TLIM     8'h6a
`define FM_REG_MAXD     8'h6b
`define FM_REG_OFFS     8'h70
`define FM_REG_DUTY     8'h30
`define FM_REG_FMODE    8'h5c
`define FM_REG_LFRATE   8'h5f
`define FM_REG_GPIO     8'h7e
`define FM_REG_STAT2    8'h42

// Reset values
`define FM_RST_EXTCFG   8'h00
`define FM_RST_CFG4     8'h00
`define FM_RST_TLIM     8'ha4
`define FM_RST_MAXD     8'hff
`define FM_RST_ZERO     8'h00

// Field positions
`define FM_EXT_LEGACY   0
`define FM_EXT_LF       1
`define FM_EXT_DIR      2
`define FM_EXT_POL      3
`define FM_FMODE_AUTO   0
`define FM_GPIO_DATA    0
`define FM_STAT2_MF     5

// Bus, encodings and timing
`define FM_SLAVE_ADDR   7'h2e
`define FM_DUTY_FULL    8'hff
`define FM_TEMP_BIAS    10'sd64
`define FM_CLK_HZ       200000000
`define FM_FS_TIMEOUT_MS 4600
`define FM_HF_PWM_DHZ   225
`define FM_LF_MIN_HZ    10
`define FM_LF_MAX_HZ    100
`define FM_PWM_STEPS    256

`endif

// [include/fm_pkg.sv]
// Types shared by the fan monitor start-up and configuration block
package fm_pkg;

    // Multifunction pin role
    typedef enum logic [1:0] {
        FM_ROLE_TACH  = 2'b00,
        FM_ROLE_THERMAL_ALARM_PIN = 2'b01,
        FM_ROLE_ALERT = 2'b10,
        FM_ROLE_GPIO  = 2'b11
    } fm_role_t;

    // Host-timeout fail-safe state
    typedef enum logic [1:0] {
        FM_FS_WAIT  = 2'b00,
        FM_FS_COUNT = 2'b01,
        FM_FS_TRIP  = 2'b10,
        FM_FS_HOST  = 2'b11
    } fm_fs_t;

    // Register write from the serial engine
    typedef struct packed {
        logic       vld;
        logic [7:0] ptr;
        logic [7:0] data;
    } fm_wr_t;

endpackage : fm_pkg

// [src/fm_startup_cfg.sv]
// Start-up, fail-safe and extended configuration logic of the fan monitor
// How it works
// - Monitoring starts on core supply, else after first own transaction ends.
// - Fan drive stays off after reset until programmed or forced.
// - Temperature above thermal limit (100 C default) forces full fan speed.
// - No addressing within 4.6 s of core supply forces full speed.
// - Writes are accepted anytime and programmed behaviour then applies.
// - Without core supply the host timeout never fires.
// - With core supply off, any write selects normal operation.
// - Offset of plus/minus 64 C in half-degree steps adjusts temperature.
// - Automatic duty is capped at a programmable maximum.
// - Extended config bit 0 selects extended or legacy temperature range.
// - Power up in the extended range.
// - Extended config bit 1 low gives 22.5 kHz PWM, the reset state.
// - Bit 1 high gives low-frequency PWM, 10 to 100 Hz programmable.
// - Bit 2 sets pin direction: input, or open-drain output.
// - Bit 3 sets pin polarity: active low or active high.
// - Pin state reads in status 2 bit 5, shared by pin roles.
// - Responds only at fixed slave address 0x2E.
// - Alert role drives the pin on out-of-limit conditions.
// - All control goes through serial-bus register accesses.
// - Config 4 bits 1:0 pick tach, thermal, alert or GPIO role.
`timescale 1ns/100ps
`include "fm_consts.svh"

module fm_startup_cfg import fm_pkg::*; #(
    parameter int NUM_FANS  = 3,                                     // Fan outputs
    parameter int FS_CYCLES = `FM_FS_TIMEOUT_MS * (`FM_CLK_HZ / 1000) // Host timeout
) (
    input  wire logic                clk,               // System clock
    input  wire logic                rst_b,             // Sync reset, active low
    input  wire logic                core_supply_input, // Core supply good, async
    input  wire logic                bus_addr_vld,      // Address byte received
    input  wire logic [6:0]          bus_addr,          // Received slave address
    input  wire logic                bus_xact_done,     // Transaction complete
    input  wire fm_wr_t              bus_wr,            // Register write
    input  wire logic [7:0]          bus_rd_ptr,        // Read pointer
    input  wire logic [7:0]          meas_temp,         // Measured temperature
    input  wire logic [7:0]          auto_duty,         // Auto loop duty request
    input  wire logic                limit_fault,       // Out-of-limit from limits
    input  wire logic [7:0]          status2_in,        // Other status 2 bits
    input  wire logic                mf_pin_i,          // Multifunction pin, async
    output logic                     addr_match,        // Own address seen
    output logic                     monitor_en,        // Monitoring running
    output logic                     failsafe,          // Fans forced full
    output logic [NUM_FANS-1:0]      fan_pwm,           // Fan drive
    output logic [7:0]               temp_adj,          // Offset-corrected temp
    output logic [7:0]               rd_data,           // Read data
    output logic                     mf_pin_o,          // Pin drive value
    output logic                     mf_pin_oe          // Pin pulls low
);

    // ************************************************************
    // Constants
    // ************************************************************
    localparam int LF_CODES = `FM_LF_MAX_HZ / `FM_LF_MIN_HZ;
    localparam int STEP_HZ  = `FM_CLK_HZ / `FM_PWM_STEPS;
    localparam logic [19:0] HF_STEP = 20'(STEP_HZ / (`FM_HF_PWM_DHZ * 100));
    localparam logic [3:0]  LF_TOP  = 4'(LF_CODES - 1);
    localparam logic [31:0] FS_LAST = 32'(FS_CYCLES - 1);
    localparam logic [1:0]  SYNC_RST = 2'b10;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] sync_raw;
    logic [2:0] sync_sh [2];
    logic [1:0] sync_q;
    logic       core_on;
    logic       mf_lvl;

    assign sync_raw = {mf_pin_i, core_supply_input};
    assign core_on  = sync_q[0];
    assign mf_lvl   = sync_q[1];

    // A change is taken only when the last two stages agree
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                sync_sh[i] <= {3{SYNC_RST[i]}};
                sync_q[i]  <= SYNC_RST[i];
            end else begin
                sync_sh[i] <= {sync_sh[i][1:0], sync_raw[i]};
                if (sync_sh[i][1] == sync_sh[i][2]) begin
                    sync_q[i] <= sync_sh[i][2];
                end
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] ext_q, cfg4_q, tlim_q, maxd_q, offs_q;
    logic [7:0] duty_q, fmode_q, lfrate_q, gpio_q;
    logic       wr;
    fm_role_t   role;

    assign wr   = bus_wr.vld;
    assign role = fm_role_t'(cfg4_q[1:0]);

    // Only the serial engine writes; nothing else reaches this state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_q    <= `FM_RST_EXTCFG;
            cfg4_q   <= `FM_RST_CFG4;
            tlim_q   <= `FM_RST_TLIM;
            maxd_q   <= `FM_RST_MAXD;
            offs_q   <= `FM_RST_ZERO;
            duty_q   <= `FM_RST_ZERO;
            fmode_q  <= `FM_RST_ZERO;
            lfrate_q <= `FM_RST_ZERO;
            gpio_q   <= `FM_RST_ZERO;
        end else if (wr) begin
            unique case (bus_wr.ptr)
                `FM_REG_EXTCFG: ext_q    <= bus_wr.data;
                `FM_REG_CFG4:   cfg4_q   <= bus_wr.data;
                `FM_REG_TLIM:   tlim_q   <= bus_wr.data;
                `FM_REG_MAXD:   maxd_q   <= bus_wr.data;
                `FM_REG_OFFS:   offs_q   <= bus_wr.data;
                `FM_REG_DUTY:   duty_q   <= bus_wr.data;
                `FM_REG_FMODE:  fmode_q  <= bus_wr.data;
                `FM_REG_LFRATE: lfrate_q <= bus_wr.data;
                `FM_REG_GPIO:   gpio_q   <= bus_wr.data;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Addressing and monitoring start
    // ************************************************************
    logic addr_hit, addr_match_q, mine_q, mon_q;

    assign addr_hit = bus_addr_vld && (bus_addr == `FM_SLAVE_ADDR);

    // Own address match and transaction ownership
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            addr_match_q <= 1'b0;
            mine_q       <= 1'b0;
        end else begin
            addr_match_q <= addr_hit;
            if (addr_hit) begin
                mine_q <= 1'b1;
            end else if (bus_xact_done) begin
                mine_q <= 1'b0;
            end
        end
    end

    // Monitoring is sticky once started
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mon_q <= 1'b0;
        end else if (core_on || (bus_xact_done && mine_q)) begin
            mon_q <= 1'b1;
        end
    end

    // ************************************************************
    // Host-timeout fail-safe
    // ************************************************************
    fm_fs_t      fs_q;
    logic [31:0] fs_cnt_q;

    // Counter runs only in COUNT, so a missing core supply never trips
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fs_q     <= FM_FS_WAIT;
            fs_cnt_q <= '0;
        end else begin
            unique case (fs_q)
                FM_FS_WAIT: begin
                    if (addr_hit || wr) begin
                        fs_q <= FM_FS_HOST;
                    end else if (core_on) begin
                        fs_q     <= FM_FS_COUNT;
                        fs_cnt_q <= '0;
                    end
                end
                FM_FS_COUNT: begin
                    if (addr_hit || wr) begin
                        fs_q <= FM_FS_HOST;
                    end else if (fs_cnt_q == FS_LAST) begin
                        fs_q <= FM_FS_TRIP;
                    end else begin
                        fs_cnt_q <= fs_cnt_q + 32'h0000_0001;
                    end
                end
                FM_FS_TRIP: begin
                    if (wr) begin
                        fs_q <= FM_FS_HOST;
                    end
                end
                FM_FS_HOST: ;
            endcase
        end
    end

    // ************************************************************
    // Temperature offset, range and over-temperature
    // ************************************************************
    logic              legacy;
    logic signed [10:0] adj_half, lim_half;
    logic signed [9:0]  adj_deg, adj_enc;
    logic              overtemp_q;

    assign legacy = ext_q[`FM_EXT_LEGACY];

    // Register code to degrees for the active range
    function automatic logic signed [9:0] to_deg(input logic [7:0] v, input logic leg);
        return leg ? {{2{v[7]}}, v} : $signed({2'b00, v}) - `FM_TEMP_BIAS;
    endfunction : to_deg

    // Work in half degrees so the offset keeps its resolution
    assign adj_half = {to_deg(meas_temp, legacy), 1'b0} + {{3{offs_q[7]}}, offs_q};
    assign lim_half = {to_deg(tlim_q, legacy), 1'b0};
    assign adj_deg  = adj_half[10:1];
    assign adj_enc  = legacy ? adj_deg : adj_deg + `FM_TEMP_BIAS;

    // Registered compare and corrected reading
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            overtemp_q <= 1'b0;
            temp_adj   <= 8'h00;
        end else begin
            overtemp_q <= mon_q && (adj_half > lim_half);
            temp_adj   <= adj_enc[7:0];
        end
    end

    // ************************************************************
    // Duty selection and PWM
    // ************************************************************
    logic [7:0]  duty_d, cap, duty_lat_q, phase_q;
    logic [19:0] lf_tab [LF_CODES];
    logic [19:0] step_lim, pre_q;
    logic [3:0]  lf_code;
    logic        force_full, step, pwm_on;

    assign force_full = overtemp_q || (fs_q == FM_FS_TRIP);
    assign cap        = (auto_duty > maxd_q) ? maxd_q : auto_duty;

    // Forcing wins over both manual and automatic duty
    always_comb begin
        if (force_full) begin
            duty_d = `FM_DUTY_FULL;
        end else if (fmode_q[`FM_FMODE_AUTO]) begin
            duty_d = cap;
        end else begin
            duty_d = duty_q;
        end
    end

    // Step length per low-frequency code, 10 Hz apart
    for (genvar i = 0; i < LF_CODES; i++) begin : g_lf
        assign lf_tab[i] = 20'(STEP_HZ / (`FM_LF_MIN_HZ * (i + 1)));
    end

    assign lf_code  = (lfrate_q[3:0] > LF_TOP) ? LF_TOP : lfrate_q[3:0];
    assign step_lim = ext_q[`FM_EXT_LF] ? lf_tab[lf_code] : HF_STEP;
    assign step     = (pre_q >= step_lim - 20'h0_0001);
    assign pwm_on   = (duty_lat_q == `FM_DUTY_FULL) || (phase_q < duty_lat_q);

    // Duty is latched at period start so a write never makes a runt pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_q      <= '0;
            phase_q    <= 8'h00;
            duty_lat_q <= `FM_RST_ZERO;
        end else begin
            pre_q <= step ? 20'h0_0000 : pre_q + 20'h0_0001;
            if (step) begin
                phase_q <= phase_q + 8'h01;
                if (phase_q == 8'hff) begin
                    duty_lat_q <= duty_d;
                end
            end
            if (force_full) begin
                duty_lat_q <= `FM_DUTY_FULL; // Fail-safe acts at once
            end
        end
    end

    // One flop per fan output
    for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                fan_pwm[f] <= 1'b0;
            end else begin
                fan_pwm[f] <= pwm_on;
            end
        end
    end

    // ************************************************************
    // Multifunction pin and read-back
    // ************************************************************
    logic pol, want_low, mf_stat;

    assign pol = ext_q[`FM_EXT_POL];

    // Open drain: the pin is only ever pulled low
    always_comb begin
        unique case (role)
            FM_ROLE_GPIO:  want_low = ext_q[`FM_EXT_DIR] && (gpio_q[`FM_GPIO_DATA] ^ pol);
            FM_ROLE_THERMAL_ALARM_PIN: want_low = overtemp_q;
            FM_ROLE_ALERT: want_low = limit_fault || overtemp_q;
            FM_ROLE_TACH:  want_low = 1'b0;
        endcase
    end

    // Asserted pin state in the GPIO and thermal roles; alert and tach roles pass status 2 bit 5 through
    always_comb begin
        unique case (role)
            FM_ROLE_GPIO:  mf_stat = ~(mf_lvl ^ pol);
            FM_ROLE_THERMAL_ALARM_PIN: mf_stat = ~mf_lvl;
            FM_ROLE_ALERT: mf_stat = status2_in[`FM_STAT2_MF];
            FM_ROLE_TACH:  mf_stat = status2_in[`FM_STAT2_MF];
        endcase
    end

    // Output flops and read mux; unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mf_pin_oe  <= 1'b0;
            mf_pin_o   <= 1'b0;
            addr_match <= 1'b0;
            monitor_en <= 1'b0;
            failsafe   <= 1'b0;
            rd_data    <= 8'h00;
        end else begin
            mf_pin_oe  <= want_low;
            mf_pin_o   <= 1'b0;
            addr_match <= addr_match_q;
            monitor_en <= mon_q;
            failsafe   <= force_full;
            unique case (bus_rd_ptr)
                `FM_REG_EXTCFG: rd_data <= ext_q;
                `FM_REG_CFG4:   rd_data <= cfg4_q;
                `FM_REG_TLIM:   rd_data <= tlim_q;
                `FM_REG_MAXD:   rd_data <= maxd_q;
                `FM_REG_OFFS:   rd_data <= offs_q;
                `FM_REG_DUTY:   rd_data <= duty_q;
                `FM_REG_FMODE:  rd_data <= fmode_q;
                `FM_REG_LFRATE: rd_data <= lfrate_q;
                `FM_REG_GPIO:   rd_data <= gpio_q;
                `FM_REG_STAT2:  rd_data <= {status2_in[7:6], mf_stat, status2_in[4:0]};
                default:        rd_data <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_hot_full:    assert property (overtemp_q |=> failsafe && duty_lat_q == `FM_DUTY_FULL)
        else $error("overtemp without full duty");
    a_fs_full:     assert property (fs_q == FM_FS_TRIP |=> failsafe)
        else $error("timeout without fail-safe");
    a_trip_time:   assert property ($rose(fs_q == FM_FS_TRIP) |-> $past(fs_cnt_q) == FS_LAST)
        else $error("timeout at wrong count");
    a_no_core:     assert property (!core_on && fs_q == FM_FS_WAIT |=> fs_q == FM_FS_WAIT || fs_q == FM_FS_HOST)
        else $error("trip without core supply");
    a_trip_write:  assert property (fs_q == FM_FS_TRIP && wr |=> fs_q == FM_FS_HOST)
        else $error("write did not leave trip");
    a_wait_write:  assert property (fs_q == FM_FS_WAIT && wr |=> fs_q == FM_FS_HOST)
        else $error("write without core not normal");
    a_mon_start:   assert property (core_on |=> ##1 monitor_en)
        else $error("monitoring not started");
    a_addr_fixed:  assert property (bus_addr_vld && bus_addr != `FM_SLAVE_ADDR |=> ##1 !addr_match)
        else $error("foreign address matched");
    a_duty_cap:    assert property (!force_full && fmode_q[`FM_FMODE_AUTO] |-> duty_d <= maxd_q)
        else $error("auto duty above cap");
    a_fans_off:    assert property (!force_full && !fmode_q[`FM_FMODE_AUTO] && duty_q == 8'h00
                                    |-> duty_d == 8'h00)
        else $error("fans on while off");
    a_gpio_input:  assert property (role == FM_ROLE_GPIO && !ext_q[`FM_EXT_DIR] |=> !mf_pin_oe)
        else $error("input pin driven");
    a_hf_step:     assert property (!ext_q[`FM_EXT_LF] |-> step_lim == HF_STEP)
        else $error("wrong high-frequency step");

    c_trip:        cover property (fs_q == FM_FS_COUNT ##1 fs_q == FM_FS_TRIP);
    c_trip_prog:   cover property (fs_q == FM_FS_TRIP && wr);
    c_mon_bus:     cover property (!core_on && bus_xact_done && mine_q);

endmodule : fm_startup_cfg

// [test/fm_host_model.sv]
// Serial-bus host master model feeding the fan monitor block
`timescale 1ns/100ps
module fm_host_model import fm_pkg::*; (
    input  wire logic       clk,           // System clock
    input  wire logic [7:0] rd_data,       // Read data from block
    output logic            bus_addr_vld,  // Address strobe
    output logic [6:0]      bus_addr,      // Address byte
    output logic            bus_xact_done, // Stop seen
    output fm_wr_t          bus_wr,        // Register write
    output logic [7:0]      bus_rd_ptr     // Read pointer
);
    // ****************************************
    // Idle levels at time zero
    // ****************************************
    initial begin
        bus_addr_vld = 1'b0;
        bus_addr = 7'h55;
        bus_xact_done = 1'b0;
        bus_wr = '{1'b0, 8'h00, 8'h00};
        bus_rd_ptr = 8'h00;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic send_addr(input logic [6:0] a);
        @(negedge clk);
        bus_addr_vld = 1'b1;
        bus_addr = a;
        @(negedge clk);
        bus_addr_vld = 1'b0;
        bus_addr = ~a;
    endtask : send_addr
    // Stop condition pulse
    task automatic end_xact();
        @(negedge clk);
        bus_xact_done = 1'b1;
        @(negedge clk);
        bus_xact_done = 1'b0;
    endtask : end_xact
    // All programming goes through register writes
    task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
        @(negedge clk);
        bus_wr = '{1'b1, p, d};
        @(negedge clk);
        bus_wr = '{1'b0, ~p, ~d};
    endtask : write_reg
    // Answer lands on the same edge that samples the pointer
    task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
        @(negedge clk);
        bus_rd_ptr = p;
        repeat (2) @(posedge clk);
        @(negedge clk);
        d = rd_data;
        bus_rd_ptr = ~p;
    endtask : read_reg
    // Legacy range needs the alarm limit in two's complement
    // Limit goes first so the range switch never meets the offset-coded limit
    task automatic go_legacy();
        write_reg(8'h6a, 8'h64);
        write_reg(8'h7c, 8'h01);
    endtask : go_legacy
endmodule : fm_host_model

// [test/tb_top.sv]
// Self-checking bench for the start-up and configuration block
`timescale 1ns/100ps
module tb_top import fm_pkg::*;;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       core = 1'b0;
    logic [7:0] meas = 8'h40;
    logic       lim_flt = 1'b0;
    logic [7:0] st2 = 8'h85;
    logic [7:0] adty = 8'h00;
    int         hi;
    logic       addr_vld, xdone, am, mon, fs, po, poe;
    logic [6:0] addr;
    fm_wr_t     wr;
    logic [7:0] rptr, rdat, tadj, v;
    logic [2:0] pwm;
    int         err_count = 0;
    int         n_compared = 0;
    // ****************************************
    // Clock and wiring
    // ****************************************
    always #2.5 clk = ~clk;
    wire pin = ~poe; // Pulled up unless the block sinks it
    fm_host_model fm_host_model_i (.clk(clk), .rd_data(rdat), .bus_addr_vld(addr_vld), .bus_addr(addr),
        .bus_xact_done(xdone), .bus_wr(wr), .bus_rd_ptr(rptr));
    // Short timeout keeps the run small
    fm_startup_cfg #(.NUM_FANS(3), .FS_CYCLES(200)) fm_startup_cfg_i (.clk(clk), .rst_b(rst_b),
        .core_supply_input(core), .bus_addr_vld(addr_vld), .bus_addr(addr), .bus_xact_done(xdone),
        .bus_wr(wr), .bus_rd_ptr(rptr), .meas_temp(meas), .auto_duty(adty), .limit_fault(lim_flt),
        .status2_in(st2), .mf_pin_i(pin), .addr_match(am), .monitor_en(mon), .failsafe(fs),
        .fan_pwm(pwm), .temp_adj(tadj), .rd_data(rdat), .mf_pin_o(po), .mf_pin_oe(poe));
    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Bounded wait: 0 failsafe, 1 monitor, 2 all fans high
    task automatic wait_sig(input int sel, input logic val, input int n);
        logic s;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            s = (sel == 0) ? fs : (sel == 1) ? mon : (pwm === 3'b111);
            if (s === val) return;
        end
        err_count++;
        $display("CHECK FAILED wait %0d expected %b", sel, val);
        end_sim();
    endtask : wait_sig
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
    endtask : do_reset
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        do_reset();
        chk("fans", {5'h0, pwm}, 8'h00);
        chk("mon", {7'h0, mon}, 8'h00);
        fm_host_model_i.read_reg(8'h7c, v);
        chk("ext_rst", v, 8'h00);
        // Silent host: timeout must not fire early, then must force full speed
        core = 1'b1;
        repeat (150) @(negedge clk);
        chk("fs_early", {7'h0, fs}, 8'h00);
        wait_sig(0, 1'b1, 200);
        chk("mon_core", {7'h0, mon}, 8'h01);
        wait_sig(2, 1'b1, 9000);
        fm_host_model_i.write_reg(8'h30, 8'h00);
        wait_sig(0, 1'b0, 10);
        wait_sig(2, 1'b0, 9000);
        // Own address pulses, a neighbour does not
        fm_host_model_i.send_addr(7'h2e);
        @(negedge clk);
        chk("own_addr", {7'h0, am}, 8'h01);
        fm_host_model_i.send_addr(7'h2f);
        @(negedge clk);
        chk("other_addr", {7'h0, am}, 8'h00);
        // Over-temperature above the default limit
        meas = 8'hc8;
        wait_sig(0, 1'b1, 10);
        meas = 8'h40;
        wait_sig(0, 1'b0, 10);
        // Offset of minus two degrees
        fm_host_model_i.write_reg(8'h70, 8'hfc);
        repeat (3) @(negedge clk);
        chk("offset", tadj, 8'h3e);
        fm_host_model_i.write_reg(8'h70, 8'h00);
        // Register map: read back, unmapped, read-only status
        fm_host_model_i.write_reg(8'h7c, 8'h0e);
        fm_host_model_i.read_reg(8'h7c, v);
        chk("ext_rw", v, 8'h0e);
        fm_host_model_i.read_reg(8'h55, v);
        chk("unmapped", v, 8'h00);
        fm_host_model_i.write_reg(8'h42, 8'hff);
        fm_host_model_i.read_reg(8'h42, v);
        chk("stat_ro", v, 8'h85);
        // GPIO output, active high
        fm_host_model_i.write_reg(8'h7d, 8'h03);
        fm_host_model_i.write_reg(8'h7c, 8'h0c);
        fm_host_model_i.write_reg(8'h7e, 8'h00);
        repeat (3) @(negedge clk);
        chk("gpio_lo", {7'h0, poe}, 8'h01);
        fm_host_model_i.write_reg(8'h7e, 8'h01);
        repeat (3) @(negedge clk);
        chk("gpio_hi", {7'h0, poe}, 8'h00);
        chk("pin_o", {7'h0, po}, 8'h00);
        fm_host_model_i.read_reg(8'h42, v);
        chk("gpio_stat", v, 8'ha5);
        // Alert role follows out-of-limit
        fm_host_model_i.write_reg(8'h7d, 8'h02);
        lim_flt = 1'b1;
        repeat (4) @(negedge clk);
        chk("alert_on", {7'h0, poe}, 8'h01);
        lim_flt = 1'b0;
        repeat (4) @(negedge clk);
        chk("alert_off", {7'h0, poe}, 8'h00);
        st2 = 8'h20;
        fm_host_model_i.read_reg(8'h42, v);
        chk("alert_stat", v, 8'h20);
        // Automatic duty 0x80 capped at 0x40: 64 of 256 steps of 34 clocks high
        fm_host_model_i.write_reg(8'h6b, 8'h40);
        fm_host_model_i.write_reg(8'h5c, 8'h01);
        adty = 8'h80;
        repeat (8800) @(negedge clk);
        hi = 0;
        repeat (8704) begin
            @(negedge clk);
            hi += int'(pwm[0]);
        end
        chk("auto_cap", {7'h0, hi == 2176}, 8'h01);
        // Legacy range: 110 degrees passes the 100 degree limit
        fm_host_model_i.go_legacy();
        repeat (3) @(negedge clk);
        chk("legacy_quiet", {7'h0, fs}, 8'h00);
        meas = 8'h6e;
        wait_sig(0, 1'b1, 10);
        meas = 8'h40;
        // No core supply: never times out, first own transaction starts monitoring
        core = 1'b0;
        do_reset();
        repeat (300) @(negedge clk);
        chk("no_core_fs", {6'h0, fs, mon}, 8'h00);
        fm_host_model_i.send_addr(7'h2e);
        fm_host_model_i.end_xact();
        wait_sig(1, 1'b1, 6);
        // Write with no core supply: a later supply must not start the timeout
        core = 1'b0;
        do_reset();
        fm_host_model_i.write_reg(8'h30, 8'h00);
        core = 1'b1;
        repeat (300) @(negedge clk);
        chk("no_core_wr", {6'h0, fs, mon}, 8'h01);
        end_sim();
    end
endmodule : tb_top
